// *** common/arsr_pkg.sv ***
// package of constants and carrier types for the converter result and status registers
`default_nettype none
package arsr_pkg;

    // ----------------------------------------------------------------
    // register offsets on the device register port
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS_FLAGS    = 8'h01;
    localparam logic [7:0] ADDR_AMP_RESULT_HIGH = 8'h02;
    localparam logic [7:0] ADDR_AMP_RESULT_LOW  = 8'h03;
    localparam logic [7:0] ADDR_AUX_RESULT_HIGH = 8'h04;
    localparam logic [7:0] ADDR_AUX_RESULT_LOW  = 8'h05;
    localparam logic [7:0] ADDR_TEMP_RESULT_HIGH = 8'h06;

    // ----------------------------------------------------------------
    // status field positions and reset values
    // ----------------------------------------------------------------
    localparam int BIT_BOOT        = 5;
    localparam int BIT_SYSCLK      = 4;
    localparam int BIT_PENDING_N   = 3;
    localparam int BIT_GAIN_SAT    = 2;
    localparam int BIT_COEF_FAULT  = 1;
    localparam int BIT_OFFSET_FAULT = 0;
    localparam logic       RST_BOOT      = 1'h1;
    localparam logic       RST_PENDING_N = 1'h1;
    localparam logic       RST_FLAG      = 1'h0;
    localparam logic [15:0] RST_RESULT   = 16'h0000;

    // ----------------------------------------------------------------
    // saturation values and source select encodings
    // ----------------------------------------------------------------
    localparam logic [15:0] SAT_POS = 16'h7FFF;
    localparam logic [15:0] SAT_NEG = 16'h8000;

    typedef enum logic [1:0]
    {
        SRC_TEMP = 2'h0,
        SRC_AMP  = 2'h1,
        SRC_AUX  = 2'h2,
        SRC_RSVD = 2'h3
    } arsr_src_t;

    // one finished conversion from the calibration path
    typedef struct packed
    {
        logic [15:0] value;
        arsr_src_t   src;
        logic        gain_ovf;
        logic        gain_ovf_neg;
        logic        offset_ovf;
    } arsr_conv_t;

    // host register read strobe
    typedef struct packed
    {
        logic       rd;
        logic [7:0] addr;
    } arsr_rd_t;

endpackage : arsr_pkg
`default_nettype wire

// *** rtl/arsr_sync.sv ***
// two-stage synchroniser for a level from another domain
`timescale 1ns/100ps
`default_nettype none
module arsr_sync
(
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_reg;

    // ----------------------------------------------------------------
    // first stage feeds only the second
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            meta_reg <= 1'h0;
            o_sync   <= 1'h0;
        end
        else
        begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule : arsr_sync
`default_nettype wire

// *** rtl/arsr_saturate.sv ***
// applies positive or negative saturation to a calibrated result
`timescale 1ns/100ps
`default_nettype none
module arsr_saturate
(
    input  wire logic [15:0] i_value,
    input  wire logic        i_ovf,
    input  wire logic        i_ovf_neg,
    output logic [15:0]      o_value
);
    // ----------------------------------------------------------------
    // clamp on gain overflow
    // ----------------------------------------------------------------
    always_comb
    begin
        if (i_ovf)
            o_value = i_ovf_neg ? arsr_pkg::SAT_NEG : arsr_pkg::SAT_POS;
        else
            o_value = i_value;
    end
endmodule : arsr_saturate
`default_nettype wire

// *** rtl/arsr_regs.sv ***
// status and result registers of the converter path
`timescale 1ns/100ps
`default_nettype none

module arsr_regs
(
    input  wire logic                 i_clk,
    input  wire logic                 i_sys_rst,
    input  wire logic                 i_boot_start,
    input  wire logic                 i_boot_done,
    input  wire logic                 i_sysclk_running,
    input  wire logic                 i_conv_valid,
    input  wire arsr_pkg::arsr_conv_t i_conv,
    input  wire logic                 i_coef_ovf,
    input  wire arsr_pkg::arsr_rd_t   i_host_rd,
    input  wire logic                 i_host_wr,
    output logic [7:0]                o_rd_data,
    output logic                      o_rd_valid,
    output logic [15:0]               o_temp_result,
    output logic                      o_temp_valid
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic        boot_reg;
    logic        pending_n_reg;
    logic        gain_sat_reg;
    logic        coef_fault_reg;
    logic        offset_fault_reg;
    logic [15:0] amplifier_result_reg;
    logic [15:0] auxiliary_result_reg;
    logic        sysclk_sync;
    logic [15:0] sat_value;
    logic        result_first_rd;
    logic        conv_amp;
    logic        conv_aux;
    logic        conv_temp;
    logic [7:0]  rd_data_next;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // first byte of amp, aux or temperature result
    function automatic logic is_first_byte(input logic [7:0] a);
        is_first_byte = (a == arsr_pkg::ADDR_AMP_RESULT_HIGH)
                     || (a == arsr_pkg::ADDR_AUX_RESULT_HIGH)
                     || (a == arsr_pkg::ADDR_TEMP_RESULT_HIGH);
    endfunction : is_first_byte

    // clock activity comes from the clock manager, another domain
    arsr_sync u_sysclk_sync
    (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_sysclk_running),
        .o_sync    (sysclk_sync)
    );

    arsr_saturate u_sat
    (
        .i_value   (i_conv.value),
        .i_ovf     (i_conv.gain_ovf),
        .i_ovf_neg (i_conv.gain_ovf_neg),
        .o_value   (sat_value)
    );

    // read and conversion decode; the write strobe only masks o_rd_valid of the read answer
    assign result_first_rd = i_host_rd.rd && is_first_byte(i_host_rd.addr);
    assign conv_amp  = i_conv_valid && (i_conv.src == arsr_pkg::SRC_AMP);
    assign conv_aux  = i_conv_valid && (i_conv.src == arsr_pkg::SRC_AUX);
    assign conv_temp = i_conv_valid && (i_conv.src == arsr_pkg::SRC_TEMP);

    // ----------------------------------------------------------------
    // boot flag: set at load start, cleared at completion
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            boot_reg <= arsr_pkg::RST_BOOT;
        else if (i_boot_start)
            boot_reg <= 1'h1;
        else if (i_boot_done)
            boot_reg <= 1'h0;
    end

    // ----------------------------------------------------------------
    // ready flag: a new result wins over a same-cycle read
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            pending_n_reg <= arsr_pkg::RST_PENDING_N;
        else if (conv_amp || conv_aux || conv_temp)
            pending_n_reg <= 1'h0;
        else if (result_first_rd)
            pending_n_reg <= 1'h1;
    end

    // ----------------------------------------------------------------
    // overflow flags: sticky, set beats clear
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            gain_sat_reg     <= arsr_pkg::RST_FLAG;
            coef_fault_reg   <= arsr_pkg::RST_FLAG;
            offset_fault_reg <= arsr_pkg::RST_FLAG;
        end
        else
        begin
            if (i_conv_valid && i_conv.gain_ovf)
                gain_sat_reg <= 1'h1;
            else if (result_first_rd)
                gain_sat_reg <= 1'h0;
            if (i_coef_ovf)
                coef_fault_reg <= 1'h1;
            else if (result_first_rd)
                coef_fault_reg <= 1'h0;
            if (i_conv_valid && i_conv.offset_ovf)
                offset_fault_reg <= 1'h1;
            else if (result_first_rd)
                offset_fault_reg <= 1'h0;
        end
    end

    // ----------------------------------------------------------------
    // result registers: whole 16-bit word loads at once so both bytes
    // always belong to one conversion
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            amplifier_result_reg <= arsr_pkg::RST_RESULT;
            auxiliary_result_reg <= arsr_pkg::RST_RESULT;
        end
        else
        begin
            if (conv_amp)
                amplifier_result_reg <= sat_value;
            if (conv_aux)
                auxiliary_result_reg <= sat_value;
        end
    end

    // temperature word goes out to its own register, kept elsewhere
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_temp_result <= arsr_pkg::RST_RESULT;
            o_temp_valid  <= 1'h0;
        end
        else
        begin
            o_temp_valid <= conv_temp;
            if (conv_temp)
                o_temp_result <= i_conv.value;
        end
    end

    // ----------------------------------------------------------------
    // read mux; unmapped offsets read zero
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_data_next = 8'h00;
        unique case (i_host_rd.addr)
            arsr_pkg::ADDR_STATUS_FLAGS:
            begin
                rd_data_next[arsr_pkg::BIT_BOOT]         = boot_reg;
                rd_data_next[arsr_pkg::BIT_SYSCLK]       = sysclk_sync;
                rd_data_next[arsr_pkg::BIT_PENDING_N]    = pending_n_reg;
                rd_data_next[arsr_pkg::BIT_GAIN_SAT]     = gain_sat_reg;
                rd_data_next[arsr_pkg::BIT_COEF_FAULT]   = coef_fault_reg;
                rd_data_next[arsr_pkg::BIT_OFFSET_FAULT] = offset_fault_reg;
            end
            arsr_pkg::ADDR_AMP_RESULT_HIGH: rd_data_next = amplifier_result_reg[15:8];
            arsr_pkg::ADDR_AMP_RESULT_LOW:  rd_data_next = amplifier_result_reg[7:0];
            arsr_pkg::ADDR_AUX_RESULT_HIGH: rd_data_next = auxiliary_result_reg[15:8];
            arsr_pkg::ADDR_AUX_RESULT_LOW:  rd_data_next = auxiliary_result_reg[7:0];
            default:                        rd_data_next = 8'h00;
        endcase
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_rd_data  <= 8'h00;
            o_rd_valid <= 1'h0;
        end
        else
        begin
            o_rd_valid <= i_host_rd.rd && !i_host_wr;
            if (i_host_rd.rd)
                o_rd_data <= rd_data_next;
        end
    end
endmodule : arsr_regs
`default_nettype wire

// *** verif/arsr_regs_checker.sv ***
// assertion checker for the converter status and result registers
`timescale 1ns/100ps
`default_nettype none
module arsr_regs_checker
(
    input wire logic                 i_clk,
    input wire logic                 i_sys_rst,
    input wire logic                 i_boot_start,
    input wire logic                 i_boot_done,
    input wire logic                 i_sysclk_running,
    input wire logic                 i_conv_valid,
    input wire arsr_pkg::arsr_conv_t i_conv,
    input wire logic                 i_coef_ovf,
    input wire arsr_pkg::arsr_rd_t   i_host_rd,
    input wire logic                 i_host_wr,
    input wire logic [7:0]           o_rd_data,
    input wire logic                 o_rd_valid
);
    // ----------------------------------------------------------------
    // helper terms
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // quiet excludes set events, since set beats clear
    wire logic rd_ok = i_host_rd.rd && !i_host_wr;
    wire logic quiet = !i_conv_valid && !i_coef_ovf && !i_boot_start && !i_boot_done;
    wire logic conv  = i_conv_valid && i_conv.src != arsr_pkg::SRC_RSVD;
    sequence s_stat_rd;
        rd_ok && i_host_rd.addr == arsr_pkg::ADDR_STATUS_FLAGS && quiet;
    endsequence
    sequence s_amp_rd;
        rd_ok && i_host_rd.addr == arsr_pkg::ADDR_AMP_RESULT_HIGH && quiet;
    endsequence
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    AST_RD_ANSWER: assert property (rd_ok |=> o_rd_valid)
        else $error("read not answered one cycle later");
    AST_WR_REFUSED: assert property (i_host_rd.rd && i_host_wr |=> !o_rd_valid)
        else $error("read with write strobe answered");
    AST_NO_SPURIOUS: assert property (!i_host_rd.rd |=> !o_rd_valid)
        else $error("answer without read");
    AST_STATUS_TOP: assert property (s_stat_rd |=> o_rd_data[7:6] == 2'h0)
        else $error("status upper bits not zero");
    AST_UNMAPPED: assert property (rd_ok && i_host_rd.addr == 8'h00 |=> o_rd_data == 8'h00)
        else $error("unmapped read not zero");
    AST_BOOT_HELD: assert property (i_boot_start ##1 s_stat_rd |=> o_rd_data[5])
        else $error("boot flag low after start");
    AST_PENDING_SET: assert property (conv ##1 s_stat_rd |=> !o_rd_data[3])
        else $error("ready bit not low after result");
    // the host lets one quiet cycle pass between two reads
    AST_FLAGS_CLEAR: assert property (s_amp_rd ##1 quiet ##1 s_stat_rd
        |=> o_rd_data[3:0] == 4'h8)
        else $error("flags not cleared by result read");
    AST_GAIN_FLAG: assert property (conv && i_conv.gain_ovf ##1 s_stat_rd |=> o_rd_data[2])
        else $error("gain overflow flag not set");
    AST_SATURATE_POS: assert property (conv && i_conv.src == arsr_pkg::SRC_AMP
        && i_conv.gain_ovf && !i_conv.gain_ovf_neg ##1 s_amp_rd |=> o_rd_data == 8'h7F)
        else $error("positive saturation wrong");
    AST_SYSCLK: assert property (i_sysclk_running [*5] ##0 s_stat_rd |=> o_rd_data[4])
        else $error("clock activity bit low");
endmodule : arsr_regs_checker

bind arsr_regs arsr_regs_checker arsr_regs_checker_i
(
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_boot_start(i_boot_start),
    .i_boot_done(i_boot_done), .i_sysclk_running(i_sysclk_running),
    .i_conv_valid(i_conv_valid), .i_conv(i_conv), .i_coef_ovf(i_coef_ovf),
    .i_host_rd(i_host_rd), .i_host_wr(i_host_wr), .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid)
);
`default_nettype wire

// *** verif/arsr_host_model.sv ***
// host model that reads device registers one byte per strobe
`timescale 1ns/100ps
`default_nettype none
module arsr_host_model
(
    input  wire logic          i_clk,
    input  wire logic          i_rd_valid,
    input  wire logic [7:0]    i_rd_data,
    output var arsr_pkg::arsr_rd_t o_host_rd,
    output var logic           o_faulted
);
    // ----------------------------------------------------------------
    // read access
    // ----------------------------------------------------------------
    time released_at;

    initial
    begin
        o_host_rd   = '{rd: 1'b0, addr: 8'hFF};
        o_faulted   = 1'b0;
        released_at = '1;
    end
    // called at a falling edge; idle address inverted so no stale value lingers
    task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        // strobe just dropped in this time step: let one edge pass before raising it again
        if (released_at == $time)
            @(negedge i_clk);
        o_host_rd = '{rd: 1'b1, addr: addr};
        @(negedge i_clk);
        ok = i_rd_valid;
        data = i_rd_data;
        o_host_rd = '{rd: 1'b0, addr: ~addr};
        released_at = $time;
        if (ok && addr == arsr_pkg::ADDR_STATUS_FLAGS)
            o_faulted = data[arsr_pkg::BIT_COEF_FAULT] | data[arsr_pkg::BIT_OFFSET_FAULT];
    endtask : read
endmodule : arsr_host_model
`default_nettype wire

// *** verif/arsr_regs_tb_top.sv ***
// self-checking bench for the converter status and result registers
`timescale 1ns/100ps
`default_nettype none
module arsr_regs_tb_top;
    logic                 clk;
    logic                 sys_rst;
    logic                 boot_start;
    logic                 boot_done;
    logic                 sysclk_running;
    logic                 conv_valid;
    arsr_pkg::arsr_conv_t conv;
    logic                 coef_ovf;
    arsr_pkg::arsr_rd_t   host_rd;
    logic                 host_wr;
    logic [7:0]           rd_data;
    logic                 rd_valid;
    logic [15:0]          temp_result;
    logic                 temp_valid;
    logic                 faulted;
    logic [7:0]           d;
    logic                 ok;
    int                   errors;
    int                   n_compared;
    int                   cycles;

    arsr_regs arsr_regs_i
    (
        .i_clk(clk), .i_sys_rst(sys_rst), .i_boot_start(boot_start), .i_boot_done(boot_done),
        .i_sysclk_running(sysclk_running), .i_conv_valid(conv_valid), .i_conv(conv),
        .i_coef_ovf(coef_ovf), .i_host_rd(host_rd), .i_host_wr(host_wr), .o_rd_data(rd_data),
        .o_rd_valid(rd_valid), .o_temp_result(temp_result), .o_temp_valid(temp_valid)
    );
    arsr_host_model arsr_host_model_i
    (
        .i_clk(clk), .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_host_rd(host_rd),
        .o_faulted(faulted)
    );

    // ----------------------------------------------------------------
    // clock, watchdog and shared tasks
    // ----------------------------------------------------------------
    always #5 clk = ~clk;
    // a hang counts as a mismatch
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            errors++;
            summarize();
        end
    end
    task automatic summarize();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic rc(input logic [7:0] addr, input logic [7:0] exp);
        arsr_host_model_i.read(addr, d, ok);
        chk("read valid", 16'h0001, {15'h0, ok});
        chk($sformatf("reg %h", addr), {8'h00, exp}, {8'h00, d});
    endtask : rc
    // one conversion pulse; f is gain, gain negative, offset
    task automatic cv(input arsr_pkg::arsr_src_t s, input logic [15:0] v, input logic [2:0] f);
        conv_valid = 1'b1;
        conv = '{value: v, src: s, gain_ovf: f[2], gain_ovf_neg: f[1], offset_ovf: f[0]};
        @(negedge clk);
        conv_valid = 1'b0;
    endtask : cv

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {clk, boot_start, boot_done, sysclk_running, conv_valid, coef_ovf, host_wr} = 7'h00;
        conv = '0;
        sys_rst = 1'b1;
        {errors, n_compared, cycles} = '0;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        rc(8'h01, 8'h28);
        sysclk_running = 1'b1;
        repeat (4) @(negedge clk);
        rc(8'h01, 8'h38);
        boot_start = 1'b1;
        @(negedge clk);
        boot_start = 1'b0;
        rc(8'h01, 8'h38);
        boot_done = 1'b1;
        @(negedge clk);
        boot_done = 1'b0;
        rc(8'h01, 8'h18);
        cv(arsr_pkg::SRC_AMP, 16'h1234, 3'h0);
        rc(8'h01, 8'h10);
        rc(8'h02, 8'h12);
        rc(8'h01, 8'h18);
        rc(8'h03, 8'h34);
        cv(arsr_pkg::SRC_AUX, 16'h0055, 3'h6);
        rc(8'h01, 8'h14);
        rc(8'h04, 8'h80);
        rc(8'h01, 8'h18);
        rc(8'h05, 8'h00);
        cv(arsr_pkg::SRC_AMP, 16'h0055, 3'h4);
        rc(8'h02, 8'h7F);
        rc(8'h03, 8'hFF);
        cv(arsr_pkg::SRC_TEMP, 16'hABCD, 3'h1);
        chk("temp word", 16'hABCD, temp_result);
        chk("temp valid", 16'h0001, {15'h0, temp_valid});
        coef_ovf = 1'b1;
        @(negedge clk);
        coef_ovf = 1'b0;
        chk("temp valid end", 16'h0000, {15'h0, temp_valid});
        rc(8'h01, 8'h13);
        chk("host fault view", 16'h0001, {15'h0, faulted});
        arsr_host_model_i.read(8'h06, d, ok);
        rc(8'h01, 8'h18);
        chk("host fault clear", 16'h0000, {15'h0, faulted});
        cv(arsr_pkg::SRC_RSVD, 16'h9999, 3'h0);
        rc(8'h01, 8'h18);
        rc(8'h02, 8'h7F);
        host_wr = 1'b1;
        arsr_host_model_i.read(8'h02, d, ok);
        host_wr = 1'b0;
        chk("read with write", 16'h0000, {15'h0, ok});
        rc(8'h03, 8'hFF);
        rc(8'h00, 8'h00);
        summarize();
    end
endmodule : arsr_regs_tb_top
`default_nettype wire
